// ---- shared/hbr_defs.svh ----
/*
 Constants of the hub bus read path: nibble codes, field counts, address masks.
 Assumes nothing; included by the package and the interface; both ends use its macros without including it.
*/
`ifndef HBR_DEFS_SVH
`define HBR_DEFS_SVH
`define HBR_NIB_START_READ 4'hd
`define HBR_NIB_WAIT_SYNC  4'h5
`define HBR_NIB_READY_SYNC 4'h0
`define HBR_NIB_TURN       4'hf
`define HBR_NIB_FLOAT      4'hf
`define HBR_ADDR_LAST      3'h6
`define HBR_WAIT_LAST      3'h1
`define HBR_SYNC_LIMIT     3'h7
`define HBR_ARRAY_BIT      22
`define HBR_ARRAY_KEEP     28'h04f_ffff
`define HBR_SIZE_1         4'h0
`define HBR_SIZE_2         4'h1
`define HBR_SIZE_4         4'h2
`define HBR_SIZE_16        4'h4
`define HBR_SIZE_128       4'h7
`define HBR_FIFO_DEPTH     2'h2
`define HBR_RST_IDLE       2'h3
`endif

// ---- shared/hbr_pkg.sv ----
/*
 Types and helper functions of the hub bus read path.
 Assumes hbr_defs.svh is on the include path.
*/
`include "hbr_defs.svh"
`default_nettype none
package hbr_pkg;
    typedef enum logic [3:0] {
        T_IDLE, T_SEL, T_ADDR, T_SIZE, T_TURN1, T_TURN2, T_WAIT, T_READY,
        T_DLO, T_DHI, T_TEND, T_SKIP
    } hbr_tstate_t;

    typedef enum logic [3:0] {
        H_IDLE, H_START, H_SEL, H_ADDR, H_SIZE, H_TURN1, H_TURN2, H_SYNC,
        H_DLO, H_DHI, H_TEND, H_REL, H_ABORT
    } hbr_hstate_t;

    typedef struct packed {
        hbr_tstate_t     st;
        logic [2:0]      cnt;
        logic [27:0]     addr;
        logic [7:0]      bytesLeft;
        logic [7:0]      reqLeft;
        logic [27:0]     reqAddr;
        logic [1:0][7:0] mem;
        logic            wrPtr;
        logic            rdPtr;
        logic [1:0]      fill;
        logic [1:0]      pend;
        logic [1:0]      drop;
        logic [3:0]      dat;
        logic            oe;
        logic [1:0]      rstMeta;
        logic [1:0]      rstSync;
        logic [3:0]      strapMeta;
        logic [3:0]      strapSync;
    } hbr_treg_t;

    typedef struct packed {
        hbr_hstate_t st;
        logic [2:0]  cnt;
        logic [3:0]  sel;
        logic [27:0] addr;
        logic [3:0]  size;
        logic [7:0]  bytesLeft;
        logic [3:0]  lowNib;
        logic        frameN;
        logic [3:0]  dat;
        logic        oe;
        logic        rspValid;
        logic [7:0]  rspData;
        logic        rspLast;
        logic        done;
        logic        fault;
    } hbr_hreg_t;

    function automatic logic sizeOk(input logic [3:0] code);
        return code == `HBR_SIZE_1 || code == `HBR_SIZE_2 || code == `HBR_SIZE_4 ||
               code == `HBR_SIZE_16 || code == `HBR_SIZE_128;
    endfunction : sizeOk

    // bytes in a burst: two to the power of the size code
    function automatic logic [7:0] byteCount(input logic [3:0] code);
        return 8'h01 << code[2:0];
    endfunction : byteCount
endpackage : hbr_pkg
`default_nettype wire

// ---- shared/hbr_if.sv ----
/*
 Four nibble lines and the frame line between host and target.
 Assumes a pull-up: undriven nibble lines read high.
*/
`include "hbr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
interface hbr_if;
    logic       frameN;
    logic [3:0] hostData;
    logic       hostOe;
    logic [3:0] tgtData;
    logic       tgtOe;
    logic [3:0] lineLevel;

    assign lineLevel = tgtOe ? tgtData : (hostOe ? hostData : `HBR_NIB_FLOAT);

    modport target (input frameN, input lineLevel, output tgtData, output tgtOe);
    modport host (output frameN, output hostData, output hostOe, input lineLevel);
endinterface : hbr_if
`default_nettype wire

// ---- hw/hbr_target.sv ----
/*
 Target end of the hub bus read: decodes the request, answers with sync
 nibbles and streams bytes fetched from a local memory port.
 Assumes host and target share clock; the memory returns reads in order.
*/
// What this block does
// - start nibble 1101b with frame low starts read
// - take part only when selector matches strap
// - seven address nibbles, most significant first
// - burst start clears size-code low address bits
// - bit 22 high: array, ignore upper bits
// - size codes 0,1,2,4,7 give 1..128 bytes
// - host drives 1111b in cycle eleven
// - target takes the lines in cycle twelve
// - wait sync 0101b for exactly two cycles
// - ready sync 0000b in cycle fifteen
// - each byte low nibble first, 2^size bytes
// - 1111b for one cycle after last data
// - then release lines back to host
// - only the read start nibble is decoded
// - frame low mid transfer aborts and releases
// - idle with frame high keeps lines released
// - either reset input low: deselected, released
`timescale 1ns/1ps
`default_nettype none
module hbr_target (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // reset pins and identity strap
    input  wire logic        ifResetN,
    input  wire logic        cpuResetN,
    input  wire logic [3:0]  strapId,
    // hub bus
    hbr_if.target            bus,
    // memory read request
    output logic             rdReqValid,
    input  wire logic        rdReqReady,
    output logic [27:0]      rdAddr,
    output logic             rdIsArray,
    // memory read data
    input  wire logic        rdRspValid,
    output logic             rdRspReady,
    input  wire logic [7:0]  rdRspData
);
    hbr_pkg::hbr_treg_t r;
    hbr_pkg::hbr_treg_t n;
    logic               reqFire;
    logic               rspFire;
    logic               push;
    logic               pop;
    logic [27:0]        base;

    function automatic logic [27:0] burstBase(input logic [27:0] a, input logic [3:0] code);
        return a & ~((28'h1 << code[2:0]) - 28'h1);
    endfunction : burstBase

    function automatic logic [27:0] decodeAddr(input logic [27:0] a);
        return a[`HBR_ARRAY_BIT] ? (a & `HBR_ARRAY_KEEP) : a;
    endfunction : decodeAddr

    assign rdReqValid = (r.reqLeft != 8'h0) && ((r.fill + r.pend) < `HBR_FIFO_DEPTH);
    assign rdAddr     = r.reqAddr;
    assign rdIsArray  = r.reqAddr[`HBR_ARRAY_BIT];
    assign rdRspReady = (r.fill != `HBR_FIFO_DEPTH) || (r.drop != 2'h0);
    // frame low pulls the drivers off in the same cycle
    assign bus.tgtOe   = r.oe & bus.frameN;
    assign bus.tgtData = r.dat;

    always_comb begin
        n = r;
        n.rstMeta   = {ifResetN, cpuResetN};
        n.rstSync   = r.rstMeta;
        n.strapMeta = strapId;
        n.strapSync = r.strapMeta;
        base        = decodeAddr(burstBase(r.addr, bus.lineLevel));

        // two-entry buffer between memory and link
        reqFire = rdReqValid & rdReqReady;
        rspFire = rdRspValid & rdRspReady;
        push    = rspFire && (r.drop == 2'h0);
        pop     = (r.st == hbr_pkg::T_DHI) && (r.fill != 2'h0);
        if (reqFire) begin
            n.reqAddr = r.reqAddr + 28'h1;
            n.reqLeft = r.reqLeft - 8'h1;
        end
        if (rspFire && !push) begin
            n.drop = r.drop - 2'h1;
        end
        if (push) begin
            n.mem[r.wrPtr] = rdRspData;
            n.wrPtr        = ~r.wrPtr;
        end
        if (pop) begin
            n.rdPtr = ~r.rdPtr;
        end
        n.fill = r.fill + {1'b0, push} - {1'b0, pop};
        n.pend = r.pend + {1'b0, reqFire} - {1'b0, push};

        unique case (r.st)
            hbr_pkg::T_IDLE, hbr_pkg::T_SKIP: begin
                n.st = r.st;
            end
            hbr_pkg::T_SEL: begin
                n.cnt = 3'h0;
                n.st  = (bus.lineLevel == r.strapSync) ? hbr_pkg::T_ADDR
                                                       : hbr_pkg::T_SKIP;
            end
            hbr_pkg::T_ADDR: begin
                n.addr = {r.addr[23:0], bus.lineLevel};
                n.cnt  = r.cnt + 3'h1;
                if (r.cnt == `HBR_ADDR_LAST) begin
                    n.st = hbr_pkg::T_SIZE;
                end
            end
            hbr_pkg::T_SIZE: begin
                if (hbr_pkg::sizeOk(bus.lineLevel)) begin
                    n.st        = hbr_pkg::T_TURN1;
                    n.bytesLeft = hbr_pkg::byteCount(bus.lineLevel);
                    n.reqLeft   = hbr_pkg::byteCount(bus.lineLevel);
                    n.reqAddr   = base;
                end else begin
                    n.st = hbr_pkg::T_SKIP;
                end
            end
            hbr_pkg::T_TURN1: begin
                n.st = hbr_pkg::T_TURN2;
            end
            hbr_pkg::T_TURN2: begin
                n.st  = hbr_pkg::T_WAIT;
                n.cnt = 3'h0;
            end
            hbr_pkg::T_WAIT: begin
                n.cnt = r.cnt + 3'h1;
                if (r.cnt == `HBR_WAIT_LAST) begin
                    n.st = hbr_pkg::T_READY;
                end
            end
            hbr_pkg::T_READY: begin
                n.st = hbr_pkg::T_DLO;
            end
            hbr_pkg::T_DLO: begin
                n.st = hbr_pkg::T_DHI;
            end
            hbr_pkg::T_DHI: begin
                n.bytesLeft = r.bytesLeft - 8'h1;
                n.st = (r.bytesLeft == 8'h1) ? hbr_pkg::T_TEND : hbr_pkg::T_DLO;
            end
            hbr_pkg::T_TEND: begin
                n.st = hbr_pkg::T_IDLE;
            end
            default: begin
                n.st = hbr_pkg::T_IDLE;
            end
        endcase

        // any frame low ends what runs; only a read start opens a new one
        if (!bus.frameN || r.rstSync != `HBR_RST_IDLE) begin
            n.reqLeft = 8'h0;
            n.fill    = 2'h0;
            n.wrPtr   = 1'b0;
            n.rdPtr   = 1'b0;
            n.drop    = n.drop + n.pend;
            n.pend    = 2'h0;
            if (r.rstSync != `HBR_RST_IDLE) begin
                n.st = hbr_pkg::T_IDLE;
            end else if (bus.lineLevel == `HBR_NIB_START_READ) begin
                n.st = hbr_pkg::T_SEL;
            end else begin
                n.st = hbr_pkg::T_IDLE;
            end
        end

        // line drive for the coming cycle
        n.oe  = 1'b1;
        n.dat = `HBR_NIB_TURN;
        unique case (n.st)
            hbr_pkg::T_TURN2: n.dat = `HBR_NIB_TURN;
            hbr_pkg::T_WAIT:  n.dat = `HBR_NIB_WAIT_SYNC;
            hbr_pkg::T_READY: n.dat = `HBR_NIB_READY_SYNC;
            hbr_pkg::T_DLO:   n.dat = n.mem[n.rdPtr][3:0];
            hbr_pkg::T_DHI:   n.dat = n.mem[n.rdPtr][7:4];
            hbr_pkg::T_TEND:  n.dat = `HBR_NIB_TURN;
            default:          n.oe  = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule : hbr_target
`default_nettype wire

// ---- hw/hbr_host.sv ----
/*
 Host end of the hub bus read: sends start, selector, address and size,
 hands the lines over, checks sync and returns the received bytes.
 Assumes the target shares clock; command accepted only while idle.
*/
`timescale 1ns/1ps
`default_nettype none
module hbr_host (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // hub bus
    hbr_if.host              bus,
    // read command
    input  wire logic        cmdValid,
    output logic             cmdReady,
    input  wire logic [3:0]  cmdSelect,
    input  wire logic [27:0] cmdAddr,
    input  wire logic [3:0]  cmdSize,
    input  wire logic        abortReq,
    // read answer
    output logic             rspValid,
    output logic [7:0]       rspData,
    output logic             rspLast,
    output logic             done,
    output logic             fault
);
    hbr_pkg::hbr_hreg_t r;
    hbr_pkg::hbr_hreg_t n;

    assign cmdReady     = r.st == hbr_pkg::H_IDLE;
    assign bus.frameN   = r.frameN;
    assign bus.hostData = r.dat;
    assign bus.hostOe   = r.oe;
    assign rspValid     = r.rspValid;
    assign rspData      = r.rspData;
    assign rspLast      = r.rspLast;
    assign done         = r.done;
    assign fault        = r.fault;

    always_comb begin
        n = r;
        n.rspValid = 1'b0;
        n.rspLast  = 1'b0;
        n.done     = 1'b0;
        n.fault    = 1'b0;
        unique case (r.st)
            hbr_pkg::H_IDLE: begin
                if (cmdValid && hbr_pkg::sizeOk(cmdSize)) begin
                    n.st        = hbr_pkg::H_START;
                    n.sel       = cmdSelect;
                    n.addr      = cmdAddr;
                    n.size      = cmdSize;
                    n.bytesLeft = hbr_pkg::byteCount(cmdSize);
                end else if (cmdValid) begin
                    n.fault = 1'b1;
                end
            end
            hbr_pkg::H_START: n.st = hbr_pkg::H_SEL;
            hbr_pkg::H_SEL: begin
                n.st  = hbr_pkg::H_ADDR;
                n.cnt = 3'h0;
            end
            hbr_pkg::H_ADDR: begin
                n.cnt  = r.cnt + 3'h1;
                n.addr = {r.addr[23:0], 4'h0};
                if (r.cnt == `HBR_ADDR_LAST) begin
                    n.st = hbr_pkg::H_SIZE;
                end
            end
            hbr_pkg::H_SIZE:  n.st = hbr_pkg::H_TURN1;
            hbr_pkg::H_TURN1: n.st = hbr_pkg::H_TURN2;
            hbr_pkg::H_TURN2: begin
                n.st  = hbr_pkg::H_SYNC;
                n.cnt = 3'h0;
            end
            hbr_pkg::H_SYNC: begin
                n.cnt = r.cnt + 3'h1;
                if (bus.lineLevel == `HBR_NIB_READY_SYNC) begin
                    n.st = hbr_pkg::H_DLO;
                end else if (bus.lineLevel != `HBR_NIB_WAIT_SYNC ||
                             r.cnt == `HBR_SYNC_LIMIT) begin
                    n.st    = hbr_pkg::H_ABORT;
                    n.fault = 1'b1;
                end
            end
            hbr_pkg::H_DLO: begin
                n.lowNib = bus.lineLevel;
                n.st     = hbr_pkg::H_DHI;
            end
            hbr_pkg::H_DHI: begin
                n.rspValid  = 1'b1;
                n.rspData   = {bus.lineLevel, r.lowNib};
                n.rspLast   = r.bytesLeft == 8'h1;
                n.bytesLeft = r.bytesLeft - 8'h1;
                n.done      = r.bytesLeft == 8'h1;
                n.st = (r.bytesLeft == 8'h1) ? hbr_pkg::H_TEND : hbr_pkg::H_DLO;
            end
            hbr_pkg::H_TEND:  n.st = hbr_pkg::H_REL;
            hbr_pkg::H_REL:   n.st = hbr_pkg::H_IDLE;
            hbr_pkg::H_ABORT: n.st = hbr_pkg::H_IDLE;
            default:          n.st = hbr_pkg::H_IDLE;
        endcase
        if (abortReq && r.st != hbr_pkg::H_IDLE && r.st != hbr_pkg::H_ABORT) begin
            n.st = hbr_pkg::H_ABORT;
        end

        // line drive for the coming cycle
        n.frameN = 1'b1;
        n.oe     = 1'b1;
        n.dat    = `HBR_NIB_TURN;
        unique case (n.st)
            hbr_pkg::H_START: begin
                n.frameN = 1'b0;
                n.dat    = `HBR_NIB_START_READ;
            end
            hbr_pkg::H_SEL:   n.dat = n.sel;
            hbr_pkg::H_ADDR:  n.dat = n.addr[27:24];
            hbr_pkg::H_SIZE:  n.dat = n.size;
            hbr_pkg::H_TURN1: n.dat = `HBR_NIB_TURN;
            hbr_pkg::H_ABORT: n.frameN = 1'b0;
            hbr_pkg::H_IDLE, hbr_pkg::H_REL: n.dat = `HBR_NIB_TURN;
            default:          n.oe = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{st: hbr_pkg::H_IDLE, frameN: 1'b1, dat: `HBR_NIB_TURN, oe: 1'b1,
                   default: '0};
        end else begin
            r <= n;
        end
    end
endmodule : hbr_host
`default_nettype wire

// ---- test/hbr_read_properties.sv ----
/*
 Link-level assertions on the nibble lines between host and target ends.
 Assumes one shared clock and plain signals taken from the joining interface.
*/
`timescale 1ns/1ps
`default_nettype none
module hbr_read_properties (
    // clock and reset
    input wire logic       clock,
    input wire logic       rst_n,
    // link signals
    input wire logic       frameN,
    input wire logic       hostOe,
    input wire logic       tgtOe,
    input wire logic [3:0] lineLevel
);
    logic [8:0] oeRun_reg;
    logic [8:0] oeRun_next;
    logic       start;

    assign start      = !frameN && lineLevel == 4'hd;
    // length of the current target drive period
    assign oeRun_next = tgtOe ? oeRun_reg + 9'h001 : 9'h000;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            oeRun_reg <= 9'h000;
        end else begin
            oeRun_reg <= oeRun_next;
        end
    end

    default clocking dc @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_HOST_TURN: assert property (start |-> ##10 (hostOe && lineLevel == 4'hf))
        else $error("host turnaround nibble missing");
    AST_HOST_OFF: assert property (start |-> ##11 !hostOe)
        else $error("host still drives in cycle twelve");
    AST_TAKE_OVER: assert property ($rose(tgtOe) |-> $past(start, 11) && lineLevel == 4'hf)
        else $error("target took the lines at the wrong cycle");
    AST_WAIT_READY: assert property ($rose(tgtOe) |=> (lineLevel == 4'h5) [*2] ##1 (lineLevel == 4'h0))
        else $error("sync nibbles wrong");
    AST_NO_CLASH: assert property (tgtOe |-> !hostOe)
        else $error("both ends drive the lines");
    AST_ABORT: assert property ((!frameN && $past(tgtOe)) |-> !tgtOe ##1 !tgtOe)
        else $error("target kept driving after abort");
    AST_END_TURN: assert property (($fell(tgtOe) && frameN) |-> $past(lineLevel) == 4'hf)
        else $error("last target nibble is not turnaround");
    AST_HAND_BACK: assert property (($fell(tgtOe) && frameN) |-> hostOe && lineLevel == 4'hf)
        else $error("host did not resume the lines");
    AST_BYTE_PAIRS: assert property (($fell(tgtOe) && frameN) |-> oeRun_reg inside {9'd7, 9'd9, 9'd13, 9'd37, 9'd261})
        else $error("drive period length not a whole burst");

    cover property ($rose(tgtOe));
    cover property (!frameN && $past(tgtOe));
    cover property ($fell(tgtOe) && frameN && oeRun_reg == 9'd261);
endmodule : hbr_read_properties
`default_nettype wire

// ---- test/tb_hub_bus_read_target.sv ----
/*
 Bench joining host and target ends; drives commands and a memory port.
 Assumes both ends share the bench clock; memory answers one cycle late.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_hub_bus_read_target;
    logic clock, rst_n, ifResetN, cpuResetN, rdReqReady, rdRspValid, cmdValid, abortReq;
    logic [3:0] strapId, cmdSelect, cmdSize;
    logic [7:0] rdRspData, rspData;
    logic [27:0] cmdAddr, rdAddr;
    logic rdReqValid, rdIsArray, rdRspReady, cmdReady, rspValid, rspLast, done, fault;
    logic [27:0] memQ[$], reqLog[$];
    logic arrLog[$];
    logic [7:0] gotBytes[$];
    logic sawOe;
    int mismatches, checks, doneCnt, faultCnt, doneBase, faultBase, lastIdx;

    hbr_if i_hbr_if ();
    hbr_target i_hbr_target (.clock(clock), .rst_n(rst_n), .ifResetN(ifResetN),
        .cpuResetN(cpuResetN), .strapId(strapId), .bus(i_hbr_if), .rdReqValid(rdReqValid),
        .rdReqReady(rdReqReady), .rdAddr(rdAddr), .rdIsArray(rdIsArray),
        .rdRspValid(rdRspValid), .rdRspReady(rdRspReady), .rdRspData(rdRspData));
    hbr_host i_hbr_host (.clock(clock), .rst_n(rst_n), .bus(i_hbr_if), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .cmdSelect(cmdSelect), .cmdAddr(cmdAddr), .cmdSize(cmdSize),
        .abortReq(abortReq), .rspValid(rspValid), .rspData(rspData), .rspLast(rspLast),
        .done(done), .fault(fault));
    hbr_read_properties i_hbr_read_properties (.clock(clock), .rst_n(rst_n),
        .frameN(i_hbr_if.frameN), .hostOe(i_hbr_if.hostOe), .tgtOe(i_hbr_if.tgtOe),
        .lineLevel(i_hbr_if.lineLevel));

    function automatic logic [7:0] dataOf(input logic [27:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction : dataOf

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // memory model and answer capture
    always @(posedge clock) begin
        if (rdReqValid && rdReqReady) begin
            memQ.push_back(rdAddr);
            reqLog.push_back(rdAddr);
            arrLog.push_back(rdIsArray);
        end
        if (rdRspValid && rdRspReady && memQ.size() > 0) memQ.pop_front();
        if (rspValid === 1'b1) begin
            gotBytes.push_back(rspData);
            if (rspLast === 1'b1) lastIdx = gotBytes.size();
        end
        if (done === 1'b1) doneCnt++;
        if (fault === 1'b1) faultCnt++;
        if (i_hbr_if.tgtOe !== 1'b0) sawOe = 1'b1;
    end
    always @(negedge clock) begin
        rdRspValid = memQ.size() > 0;
        rdRspData  = (memQ.size() > 0) ? dataOf(memQ[0]) : 8'h00;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic expect_true(input logic cond, input string msg);
        checks++;
        if (cond !== 1'b1) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : expect_true

    // a wait that used up its bound counts as a mismatch and ends the run
    task automatic giveUp(input string msg);
        mismatches++;
        $display("unexpected at %0t: %s", $time, msg);
        print_verdict();
    endtask : giveUp

    task automatic sendCmd(input logic [3:0] sel, input logic [27:0] addr, input logic [3:0] sz);
        int i;
        for (i = 0; i < 50 && cmdReady !== 1'b1; i++) @(negedge clock);
        expect_true(cmdReady, "host not idle");
        if (cmdReady !== 1'b1) print_verdict();
        gotBytes.delete();
        lastIdx = 0;
        reqLog.delete();
        arrLog.delete();
        sawOe = 1'b0;
        doneBase = doneCnt;
        faultBase = faultCnt;
        cmdSelect = sel;
        cmdAddr = addr;
        cmdSize = sz;
        cmdValid = 1'b1;
        @(negedge clock);
        cmdValid = 1'b0;
    endtask : sendCmd

    task automatic waitEnd;
        int i;
        for (i = 0; i < 600 && doneCnt == doneBase && faultCnt == faultBase; i++) begin
            @(negedge clock);
        end
        if (i == 600) giveUp("read never ended");
        repeat (3) @(negedge clock);
    endtask : waitEnd

    task automatic checkBurst(input logic [27:0] addr, input logic [3:0] sz, input logic arr);
        logic [27:0] base;
        int n;
        int i;
        n = 1 << sz[2:0];
        base = 28'((arr ? (addr & 28'h04f_ffff) : addr) & ~(n - 1));
        sendCmd(strapId, addr, sz);
        waitEnd();
        expect_true(doneCnt == doneBase + 1, "no done");
        expect_true(gotBytes.size() == n, "byte count");
        expect_true(lastIdx == n, "last flag not on final byte");
        expect_true(reqLog.size() > 0 && reqLog[0] === base, "burst base");
        expect_true(arrLog.size() > 0 && arrLog[0] === arr, "array select");
        for (i = 0; i < n && i < gotBytes.size(); i++) begin
            expect_true(gotBytes[i] === dataOf(28'(base + i)), "byte data");
        end
    endtask : checkBurst

    task automatic scnBursts;
        logic [3:0] codes[5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h7};
        foreach (codes[k]) checkBurst(28'hfe5_a37d, codes[k], 1'b1);
        checkBurst(28'hf93_b2c7, 4'h2, 1'b0);
    endtask : scnBursts

    task automatic scnMismatch;
        sendCmd(strapId ^ 4'h3, 28'h040_0010, 4'h0);
        waitEnd();
        expect_true(!sawOe, "target drove for other selector");
        expect_true(gotBytes.size() == 0 && faultCnt > faultBase, "host saw no fault");
        sendCmd(strapId, 28'h040_0020, 4'h3);
        waitEnd();
        expect_true(!sawOe && faultCnt > faultBase, "bad size not refused");
        checkBurst(28'h041_0123, 4'h1, 1'b1);
    endtask : scnMismatch

    task automatic scnAbort;
        int i;
        sendCmd(strapId, 28'h045_6780, 4'h7);
        for (i = 0; i < 100 && gotBytes.size() < 3; i++) @(negedge clock);
        if (i == 100) giveUp("no bytes before abort");
        abortReq = 1'b1;
        repeat (2) @(negedge clock);
        expect_true(i_hbr_if.tgtOe === 1'b0, "lines held after abort");
        abortReq = 1'b0;
        repeat (20) @(negedge clock);
        expect_true(gotBytes.size() < 128, "abort ignored");
        checkBurst(28'h047_0042, 4'h0, 1'b1);
    endtask : scnAbort

    task automatic scnPinReset(input logic which);
        if (which) ifResetN = 1'b0;
        else cpuResetN = 1'b0;
        repeat (4) @(negedge clock);
        sendCmd(strapId, 28'h040_0100, 4'h0);
        waitEnd();
        expect_true(!sawOe && faultCnt > faultBase, "target active in reset");
        ifResetN = 1'b1;
        cpuResetN = 1'b1;
        repeat (4) @(negedge clock);
        checkBurst(28'h040_0105, 4'h0, 1'b1);
    endtask : scnPinReset

    initial begin
        rst_n = 1'b0;
        ifResetN = 1'b1;
        cpuResetN = 1'b1;
        strapId = 4'h9;
        rdReqReady = 1'b1;
        rdRspValid = 1'b0;
        rdRspData = 8'h00;
        cmdValid = 1'b0;
        cmdSelect = 4'h0;
        cmdAddr = 28'h000_0000;
        cmdSize = 4'h0;
        abortReq = 1'b0;
        sawOe = 1'b0;
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        expect_true(i_hbr_if.tgtOe === 1'b0, "lines driven while idle");
        scnBursts();
        scnMismatch();
        scnAbort();
        scnPinReset(1'b1);
        scnPinReset(1'b0);
        print_verdict();
    end
endmodule : tb_hub_bus_read_target
`default_nettype wire
